// *** design/ascs_div.sv ***
// ascs_div: divider that emits a one-cycle enable every div_in cycles.
// assumes div_in is steady while enable is high; 1 gives every cycle.
`timescale 1ns/1ps
module ascs_div #(
   parameter int unsigned W = 8
) (
   // clock and reset
   input  wire logic         ref_clk_in,
   input  wire logic         rst_in,
   // control
   input  wire logic         run_in,
   input  wire logic [W-1:0] div_in,
   // enable pulse
   output logic              tick_out
);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         tick_nxt;

   // count up and fire when the next count reaches div_in; stopped counter restarts cleanly
   always_comb begin
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      if (!run_in) begin
         cnt_nxt = '0;
      end else if (cnt_r + W'(1) >= div_in) begin
         cnt_nxt  = '0;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + W'(1);
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r    <= '0;
         tick_out <= 1'b0;
      end else begin
         cnt_r    <= cnt_nxt;
         tick_out <= tick_nxt;
      end
   end

endmodule : ascs_div

// *** design/ascs_pkg.sv ***
// ascs_pkg: constants and carrier types for the analog system clock switch.
// assumes a single 200 MHz reference clock; all slower rates are enables.
package ascs_pkg;

   // ****************************************
   // clock rates and derived counts
   // ****************************************
   localparam int unsigned REF_CLK_MHZ       = 200;
   localparam int unsigned CFG_MUX_MAX_MHZ   = 10;
   localparam int unsigned ADC_MAX_MHZ       = 10;
   localparam int unsigned NVM_MAX_MHZ       = 100;
   // smallest legal divide that keeps a rate at or below its ceiling (rounded up)
   localparam int unsigned INIT_DIV_MIN      = (REF_CLK_MHZ + CFG_MUX_MAX_MHZ - 1) / CFG_MUX_MAX_MHZ;
   localparam int unsigned NVM_DIV_MIN       = (REF_CLK_MHZ + NVM_MAX_MHZ - 1) / NVM_MAX_MHZ;
   // default divides; init strictly below its ceiling, adc exactly at its ceiling
   localparam int unsigned INIT_DIV_DEF      = INIT_DIV_MIN + 1;
   localparam int unsigned RUN_DIV_DEF       = 5;
   localparam int unsigned ADC_DIV_STEP      = 4;
   localparam int unsigned ADC_DIV_CODE_DEF  = 1;
   // gap countdown start for a clock switch; the gap lasts SWITCH_GAP_CYC + 1 ref clock cycles
   localparam int unsigned SWITCH_GAP_CYC    = 2;
   localparam int unsigned MUX_CLIENTS_MAX   = 64;
   localparam int unsigned RESET_CNT_VAL     = 0;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      ASCS_SEL_INIT  = 2'h0,
      ASCS_SEL_GAP   = 2'h1,
      ASCS_SEL_RUN   = 2'h2
   } ascs_sel_t;

   // user request to nonvolatile memory
   typedef struct packed {
      logic        req;
      logic [15:0] addr;
   } ascs_nvm_req_t;

   // crystal control pair toward the oscillator
   typedef struct packed {
      logic select;
      logic mode;
   } ascs_xtal_t;

endpackage : ascs_pkg

// *** design/ascs_top.sv ***
// ascs_top: clock selection for the analog system core and flash memory block.
// assumes init_done and user requests come from other clock logic (synchronised here).
// Contract
// - init clock during initialization, then run clock
// - completion flag selects the glitchless clock mux
// - above 10 MHz only if never accessed
// - init clock below 10 MHz during init
// - wide selector limits init engine clock rate
// - ADC clock from run clock, below 10 MHz (defaults give exactly 10 MHz)
// - ADC divider only multiples of four
// - drive crystal select and mode when used
// - init engine has priority over user nvm
`timescale 1ns/1ps
module ascs_top #(
   parameter int unsigned DIV_W       = 8,
   parameter int unsigned INIT_DIV    = ascs_pkg::INIT_DIV_DEF,
   parameter int unsigned RUN_DIV     = ascs_pkg::RUN_DIV_DEF,
   parameter int unsigned ADC_CODE    = ascs_pkg::ADC_DIV_CODE_DEF,
   parameter int unsigned NVM_DIV     = ascs_pkg::NVM_DIV_MIN,
   parameter int unsigned MUX_CLIENTS = ascs_pkg::MUX_CLIENTS_MAX
) (
   // clock and reset
   input  wire logic                    ref_clk_in,
   input  wire logic                    rst_in,
   // initialization status from flash memory block
   input  wire logic                    init_done_in,
   input  wire logic                    init_req_in,
   // counter and crystal
   input  wire logic                    counter_used_in,
   input  wire logic                    osc_tick_in,
   // user nonvolatile memory and config mux access
   input  wire ascs_pkg::ascs_nvm_req_t user_nvm_in,
   input  wire logic                    user_cfg_req_in,
   // clock enables
   output logic                         sys_clk_en_out,
   output logic                         cfg_mux_clk_en_out,
   output logic                         adc_clk_en_out,
   output logic                         counter_clk_en_out,
   output logic                         nvm_clk_en_out,
   // status and grants
   output ascs_pkg::ascs_sel_t          clk_sel_out,
   output ascs_pkg::ascs_xtal_t         xtal_out,
   output logic                         init_grant_out,
   output logic                         user_grant_out,
   output logic                         user_cfg_grant_out
);

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic [4:0] async_in;
   assign async_in = {init_done_in, init_req_in, osc_tick_in, user_nvm_in.req, user_cfg_req_in};

   // two stages; first stage read only by the second
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= async_in;
         sync2_r <= sync1_r;
      end
   end

   logic done_s, ireq_s, osc_s, ureq_s, ucfg_s;
   assign {done_s, ireq_s, osc_s, ureq_s, ucfg_s} = sync2_r;

   // ****************************************
   // selection state
   // ****************************************
   ascs_pkg::ascs_sel_t sel_r, sel_nxt;
   logic [1:0]          gap_r, gap_nxt;
   logic                init_tick, run_tick, adc_tick, nvm_tick;
   logic                osc_prev_r;

   // a dead gap of no system enables between clocks keeps the switch runt-free
   always_comb begin
      sel_nxt = sel_r;
      gap_nxt = gap_r;
      unique case (sel_r)
         ascs_pkg::ASCS_SEL_INIT: begin
            if (done_s) begin
               sel_nxt = ascs_pkg::ASCS_SEL_GAP;
               gap_nxt = 2'(ascs_pkg::SWITCH_GAP_CYC);
            end
         end
         ascs_pkg::ASCS_SEL_GAP: begin
            if (gap_r == 2'h0) begin
               sel_nxt = ascs_pkg::ASCS_SEL_RUN;
            end else begin
               gap_nxt = gap_r - 2'h1;
            end
         end
         ascs_pkg::ASCS_SEL_RUN: begin
            if (!done_s) begin
               sel_nxt = ascs_pkg::ASCS_SEL_INIT; // re-init returns to slow clock
            end
         end
         default: sel_nxt = ascs_pkg::ASCS_SEL_INIT;
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sel_r <= ascs_pkg::ASCS_SEL_INIT;
         gap_r <= '0;
      end else begin
         sel_r <= sel_nxt;
         gap_r <= gap_nxt;
      end
   end

   // ****************************************
   // dividers
   // ****************************************
   // init rate kept below config mux ceiling; wide selector wants it slow
   ascs_div #(.W(DIV_W)) u_init_div (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .run_in     (1'b1),
      .div_in     (DIV_W'(INIT_DIV)),
      .tick_out   (init_tick)
   );
   ascs_div #(.W(DIV_W)) u_run_div (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .run_in     (1'b1),
      .div_in     (DIV_W'(RUN_DIV)),
      .tick_out   (run_tick)
   );
   // adc divide counts run ticks in steps of four
   logic [DIV_W-1:0] adc_cnt_r, adc_cnt_nxt;
   logic             adc_tick_nxt;
   localparam logic [DIV_W-1:0] ADC_DIV = DIV_W'(ascs_pkg::ADC_DIV_STEP * ADC_CODE);
   always_comb begin
      adc_cnt_nxt  = adc_cnt_r;
      adc_tick_nxt = 1'b0;
      if (sel_r != ascs_pkg::ASCS_SEL_RUN) begin
         adc_cnt_nxt = '0; // stale count would shorten the first divide after re-entry
      end else if (run_tick) begin
         if (adc_cnt_r + DIV_W'(1) >= ADC_DIV) begin
            adc_cnt_nxt  = '0;
            adc_tick_nxt = 1'b1;
         end else begin
            adc_cnt_nxt = adc_cnt_r + DIV_W'(1);
         end
      end
   end
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         adc_cnt_r <= '0;
         adc_tick  <= 1'b0;
      end else begin
         adc_cnt_r <= adc_cnt_nxt;
         adc_tick  <= adc_tick_nxt;
      end
   end
   ascs_div #(.W(DIV_W)) u_nvm_div (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .run_in     (1'b1),
      .div_in     (DIV_W'(NVM_DIV)),
      .tick_out   (nvm_tick)
   );

   // ****************************************
   // outputs
   // ****************************************
   logic sys_nxt, cfg_nxt, ctr_nxt, ig_nxt, ug_nxt, ucg_nxt;
   always_comb begin
      // no system enable during the gap state
      sys_nxt = (sel_r == ascs_pkg::ASCS_SEL_INIT) ? init_tick :
                (sel_r == ascs_pkg::ASCS_SEL_RUN)  ? run_tick : 1'b0;
      // config mux stays on the slow clock so later access remains legal
      cfg_nxt = init_tick;
      ctr_nxt = counter_used_in & osc_s & ~osc_prev_r;
      ig_nxt  = ireq_s & (sel_r == ascs_pkg::ASCS_SEL_INIT);
      ug_nxt  = ureq_s & ~ig_nxt & nvm_tick;
      ucg_nxt = ucfg_s & init_tick & (sel_r == ascs_pkg::ASCS_SEL_RUN);
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sys_clk_en_out     <= 1'b0;
         cfg_mux_clk_en_out <= 1'b0;
         adc_clk_en_out     <= 1'b0;
         counter_clk_en_out <= 1'b0;
         nvm_clk_en_out     <= 1'b0;
         clk_sel_out        <= ascs_pkg::ASCS_SEL_INIT;
         xtal_out           <= '0;
         init_grant_out     <= 1'b0;
         user_grant_out     <= 1'b0;
         user_cfg_grant_out <= 1'b0;
         osc_prev_r         <= 1'b0;
      end else begin
         sys_clk_en_out     <= sys_nxt;
         cfg_mux_clk_en_out <= cfg_nxt;
         adc_clk_en_out     <= adc_tick;
         counter_clk_en_out <= ctr_nxt;
         nvm_clk_en_out     <= nvm_tick;
         clk_sel_out        <= sel_r;
         xtal_out           <= '{select: counter_used_in, mode: counter_used_in};
         init_grant_out     <= ig_nxt;
         user_grant_out     <= ug_nxt;
         user_cfg_grant_out <= ucg_nxt;
         osc_prev_r         <= osc_s;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   sequence done_seen_s;
      (sel_r == ascs_pkg::ASCS_SEL_INIT) && done_s;
   endsequence
   sequence to_run_s;
      (sel_r == ascs_pkg::ASCS_SEL_GAP) [*3] ##1 (sel_r == ascs_pkg::ASCS_SEL_RUN);
   endsequence
   switch_order_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      done_seen_s |=> to_run_s) else $error("switch did not follow completion");
   gap_quiet_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (sel_r == ascs_pkg::ASCS_SEL_GAP) |=> !sys_clk_en_out) else $error("enable during gap");
   init_clock_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (sel_r == ascs_pkg::ASCS_SEL_INIT) && init_tick |=> sys_clk_en_out) else $error("init tick lost");
   cfg_rate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(cfg_mux_clk_en_out) |=> !cfg_mux_clk_en_out [*2]) else $error("config clock too fast");
   adc_gate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      adc_tick |-> $past(sel_r) == ascs_pkg::ASCS_SEL_RUN) else $error("adc ran outside run");
   prio_grant_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !(init_grant_out && user_grant_out)) else $error("both grants");
   ctr_gate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !$past(counter_used_in) |-> !counter_clk_en_out) else $error("counter clock while unused");
   xtal_drive_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $past(counter_used_in) |-> xtal_out.select && xtal_out.mode) else $error("crystal not driven");

endmodule : ascs_top

// *** testbench/analog_system_clock_switch_test.sv ***
// analog_system_clock_switch_test: self-checking bench for ascs_top.
// assumes design defaults; enables are periodic, so windows count exactly.
`timescale 1ns/1ps
module analog_system_clock_switch_test;
   localparam int WIN = 420;
   logic                    ref_clk_in = 1'b0;
   logic                    rst_in = 1'b1;
   logic                    init_done_in = 1'b0;
   logic                    init_req_in = 1'b0;
   logic                    counter_used_in = 1'b0;
   logic                    user_cfg_req_in = 1'b0;
   logic                    osc_run = 1'b0;
   logic                    osc_tick_in;
   ascs_pkg::ascs_nvm_req_t user_nvm_in = '0;
   logic                    sys_en, cfg_en, adc_en, cnt_en, nvm_en, init_grant, user_grant, cfg_grant;
   ascs_pkg::ascs_sel_t     clk_sel;
   ascs_pkg::ascs_xtal_t    xtal;
   int                      osc_edges;
   int                      errors = 0;
   int                      check_count = 0;
   int                      cyc = 0;
   int                      cnt_total = 0;
   int                      n[8];

   ascs_top ascs_top_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .init_done_in(init_done_in),
      .init_req_in(init_req_in), .counter_used_in(counter_used_in), .osc_tick_in(osc_tick_in),
      .user_nvm_in(user_nvm_in), .user_cfg_req_in(user_cfg_req_in), .sys_clk_en_out(sys_en),
      .cfg_mux_clk_en_out(cfg_en), .adc_clk_en_out(adc_en), .counter_clk_en_out(cnt_en),
      .nvm_clk_en_out(nvm_en), .clk_sel_out(clk_sel), .xtal_out(xtal), .init_grant_out(init_grant),
      .user_grant_out(user_grant), .user_cfg_grant_out(cfg_grant));
   ascs_osc_model ascs_osc_model_inst (.run_in(osc_run), .xtal_in(xtal), .osc_out(osc_tick_in),
      .edges_out(osc_edges));

   // clock, hang guard and counter-enable tally
   always #2.5 ref_clk_in = ~ref_clk_in;
   // tally on the falling edge, clear of the edge that launches the enable
   always @(negedge ref_clk_in) begin
      cyc++;
      if (cnt_en === 1'b1) cnt_total++;
      if (cyc == 5000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic chk_n(string what, int exp, int got);
      check_count++;
      if (got != exp) begin
         errors++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_n

   task automatic chk_v(string what, logic [1:0] exp, logic [1:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_v

   // tally every enable but the counter's, and every grant, over a window of falling edges
   task automatic measure(int cycles);
      n = '{default: 0};
      repeat (cycles) begin
         @(negedge ref_clk_in);
         n[0] += sys_en;
         n[1] += cfg_en;
         n[2] += adc_en;
         n[3] += nvm_en;
         n[4] += user_grant;
         n[5] += cfg_grant;
         n[6] += init_grant;
         if ($isunknown({sys_en, cfg_en, adc_en, nvm_en, user_grant, cfg_grant, init_grant})) n[7]++;
      end
   endtask : measure

   // all requests held high while initialization runs
   task automatic init_window();
      init_req_in      = 1'b1;
      user_nvm_in.req  = 1'b1;
      user_cfg_req_in  = 1'b1;
      repeat (8) @(negedge ref_clk_in);
      measure(WIN);
      chk_n("init sys", WIN / ascs_pkg::INIT_DIV_DEF, n[0]);
      chk_n("init cfg", WIN / ascs_pkg::INIT_DIV_DEF, n[1]);
      chk_n("init adc", 0, n[2]);
      chk_n("init nvm", WIN / ascs_pkg::NVM_DIV_MIN, n[3]);
      chk_n("init user grant", 0, n[4]);
      chk_n("init cfg grant", 0, n[5]);
      chk_n("init grant", WIN, n[6]);
      chk_n("init unknown", 0, n[7]);
   endtask : init_window

   // completion flag steers the mux through a quiet gap
   task automatic switch_run();
      int k;
      int s;
      init_req_in  = 1'b0;
      init_done_in = 1'b1;
      k = 0;
      s = 0;
      while (clk_sel !== ascs_pkg::ASCS_SEL_GAP && k < 8) begin
         @(negedge ref_clk_in);
         k++;
      end
      chk_v("sel gap", ascs_pkg::ASCS_SEL_GAP, clk_sel);
      k = 0;
      while (clk_sel === ascs_pkg::ASCS_SEL_GAP && k < 8) begin
         s += sys_en;
         @(negedge ref_clk_in);
         k++;
      end
      chk_n("gap length", 3, k);
      chk_n("gap sys", 0, s);
      chk_v("sel run", ascs_pkg::ASCS_SEL_RUN, clk_sel);
   endtask : switch_run

   task automatic run_window();
      repeat (8) @(negedge ref_clk_in);
      measure(WIN);
      chk_n("run sys", WIN / ascs_pkg::RUN_DIV_DEF, n[0]);
      chk_n("run cfg", WIN / ascs_pkg::INIT_DIV_DEF, n[1]);
      chk_n("run adc", WIN / (ascs_pkg::RUN_DIV_DEF * ascs_pkg::ADC_DIV_STEP), n[2]);
      chk_n("run nvm", WIN / ascs_pkg::NVM_DIV_MIN, n[3]);
      chk_n("run user grant", WIN / ascs_pkg::NVM_DIV_MIN, n[4]);
      chk_n("run cfg grant", WIN / ascs_pkg::INIT_DIV_DEF, n[5]);
      chk_n("run init grant", 0, n[6]);
      chk_n("run unknown", 0, n[7]);
      init_done_in = 1'b0;
      repeat (6) @(negedge ref_clk_in);
      chk_v("sel back", ascs_pkg::ASCS_SEL_INIT, clk_sel);
   endtask : run_window

   // oscillator edges must each give one counter enable
   task automatic counter_run();
      counter_used_in = 1'b1;
      repeat (4) @(negedge ref_clk_in);
      chk_v("xtal on", 2'h3, xtal);
      cnt_total = 0;
      osc_run   = 1'b1;
      repeat (400) @(negedge ref_clk_in);
      osc_run = 1'b0;
      repeat (8) @(negedge ref_clk_in);
      chk_n("counter ticks", osc_edges, cnt_total);
      counter_used_in = 1'b0;
      repeat (4) @(negedge ref_clk_in);
      chk_v("xtal off", 2'h0, xtal);
   endtask : counter_run

   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (2) @(negedge ref_clk_in);
      chk_v("reset sel", ascs_pkg::ASCS_SEL_INIT, clk_sel);
      rst_in = 1'b0;
      init_window();
      switch_run();
      run_window();
      counter_run();
      print_verdict();
   end
endmodule : analog_system_clock_switch_test

// *** testbench/ascs_osc_model.sv ***
// ascs_osc_model: crystal oscillator standing beside the clock switch.
// assumes select and mode come from the block; output grounded when idle.
`timescale 1ns/1ps
module ascs_osc_model (
   // control from bench and block
   input  wire logic                 run_in,
   input  wire ascs_pkg::ascs_xtal_t xtal_in,
   // oscillator output and its rising-edge count
   output logic                      osc_out,
   output int                        edges_out
);
   // slow, unrelated period so every edge survives the two-flop sync
   initial begin
      osc_out   = 1'b0;
      edges_out = 0;
      forever begin
         #23;
         if (run_in && xtal_in.select && xtal_in.mode) begin
            osc_out = ~osc_out;
            if (osc_out) edges_out++;
         end else begin
            osc_out = 1'b0; // unused counter input sits at ground
         end
      end
   end
endmodule : ascs_osc_model
